// >>> verification/apb_master_model.sv
// apb master standing in for the local controller on the register port
// assumes pclk rising-edge timing; slave may insert any number of wait cycles
`timescale 1ns/1ps

module apb_master_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 10'h000;
        pwdata  = 32'h0000_0000;
    end

    // one transfer; address and write data get inverted on release so stale values never look valid
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no own limit: only the bench timeout may end a stalled access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~wd;
        paddr   <= ~{idx, 2'b00};
    endtask
endmodule

// >>> verification/buffer_pointer_regs_tb.sv
// self-checking bench for the buffer pointer register bank
// assumes apb_master_model on the register port; one clock, async reset
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module buffer_pointer_regs_tb;
    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        scsi_reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  buffer_size_code;
    logic [21:0] disk_address;
    logic [21:0] host_address;
    logic [21:0] stop_address;
    logic        host_at_stop;
    logic        buffer_halt;
    logic [7:0]  m [8'h56:8'h5f];
    logic [31:0] rd;
    logic        er;
    logic [7:0]  i;
    int          b;
    int          n_mismatch;
    int          compares;
    int          cyc;

    buffer_pointer_regs u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scsi_reset_n(scsi_reset_n),
        .buffer_size_code(buffer_size_code), .disk_address(disk_address),
        .host_address(host_address), .stop_address(stop_address),
        .host_at_stop(host_at_stop), .buffer_halt(buffer_halt));

    apb_master_model u_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2.5 pclk = ~pclk;

    function automatic logic [7:0] msk(input logic [7:0] x);
        return (x == 8'h59 || x == 8'h5c || x == 8'h5f) ? 8'h3f : 8'hff;
    endfunction

    function automatic logic [21:0] ptr(input logic [7:0] lo);
        return {m[lo + 8'h2][5:0], m[lo + 8'h1], m[lo]};
    endfunction

    task automatic wr(input logic [7:0] x, input logic [7:0] d);
        u_mst.xfer(1'b1, x, {24'h000000, d}, rd, er);
        if (x >= 8'h56) m[x] = d & msk(x);
        #1;
    endtask

    task automatic rdchk(input logic [7:0] x, input logic [7:0] e);
        u_mst.xfer(1'b0, x, 32'h0000_0000, rd, er);
        `CHK("prdata", {24'h000000, e}, rd)
    endtask

    task automatic setp(input logic [7:0] lo, input logic [21:0] v);
        wr(lo, v[7:0]);
        wr(lo + 8'h1, v[15:8]);
        wr(lo + 8'h2, {2'b00, v[21:16]});
    endtask

    task automatic chk_outs;
        `CHK("buffer_size_code", m[8'h56], buffer_size_code)
        `CHK("disk_address", ptr(8'h57), disk_address)
        `CHK("host_address", ptr(8'h5a), host_address)
        `CHK("stop_address", ptr(8'h5d), stop_address)
    endtask

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        clk_en = 1'b1;
        scsi_reset_n = 1'b1;
        n_mismatch = 0;
        compares = 0;
        cyc = 0;
        for (i = 8'h56; i <= 8'h5f; i++) m[i] = 8'h00;
        rd = $urandom(50153);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk_outs();
        `CHK("buffer_halt", 1'b1, buffer_halt)
        rdchk(8'h53, 8'h20);
        u_mst.xfer(1'b1, 8'h57, 32'h0000_00a5, rd, er);
        rdchk(8'h57, 8'h00);
        wr(8'h53, 8'h00);
        `CHK("buffer_halt", 1'b0, buffer_halt)
        $display("test reset values done");
        repeat (60) wr(8'h56 + 8'($urandom_range(9)), 8'($urandom));
        for (i = 8'h56; i <= 8'h5f; i++) rdchk(i, m[i]);
        chk_outs();
        u_mst.xfer(1'b1, 8'h00, 32'hffff_ffff, rd, er);
        `CHK("pslverr", 1'b1, er)
        u_mst.xfer(1'b0, 8'h70, 32'h0000_0000, rd, er);
        `CHK("prdata", 32'h0000_0000, rd)
        `CHK("pslverr", 1'b1, er)
        $display("test random access done");
        // a write while the clock enable is low must be lost
        @(posedge pclk);
        clk_en <= 1'b0;
        u_mst.xfer(1'b1, 8'h57, {24'h000000, ~m[8'h57]}, rd, er);
        @(posedge pclk);
        clk_en <= 1'b1;
        #1;
        chk_outs();
        $display("test clock enable done");
        // each size code: a difference above the kept bits is ignored, just below is seen
        for (int k = 0; k < 8; k++) begin
            b = int'(buffer_pointer_pkg::BUFFER_BITS[k]);
            wr(8'h56, 8'((1 << k) - 1));
            setp(8'h5a, 22'h000000);
            setp(8'h5d, (b < 22) ? (22'h000001 << b) : 22'h000000);
            `CHK("host_at_stop", 1'b1, host_at_stop)
            setp(8'h5d, 22'h000001 << (b - 1));
            `CHK("host_at_stop", 1'b0, host_at_stop)
        end
        $display("test size compare done");
        setp(8'h57, 22'($urandom));
        setp(8'h5a, 22'($urandom));
        setp(8'h5d, 22'($urandom));
        @(posedge pclk);
        scsi_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        scsi_reset_n <= 1'b1;
        repeat (8) @(posedge pclk);
        #1;
        for (i = 8'h5a; i <= 8'h5f; i++) m[i] = 8'h00;
        chk_outs();
        `CHK("host_at_stop", 1'b1, host_at_stop)
        $display("test scsi reset done");
        setp(8'h5a, 22'($urandom));
        wr(8'h53, 8'h20);
        for (i = 8'h57; i <= 8'h5f; i++) m[i] = 8'h00;
        // the clear follows one edge after the bit is set
        @(posedge pclk);
        #1;
        chk_outs();
        `CHK("buffer_halt", 1'b1, buffer_halt)
        wr(8'h53, 8'h00);
        $display("test soft reset done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("buffer_size_code", 8'h00, buffer_size_code)
        `CHK("buffer_halt", 1'b1, buffer_halt)
        for (i = 8'h56; i <= 8'h5f; i++) m[i] = 8'h00;
        chk_outs();
        `CHK("host_at_stop", 1'b1, host_at_stop)
        $display("test hardware reset done");
        summarize();
    end
endmodule

// >>> verilog/buffer_pointer_pkg.sv
// constants for the buffer pointer register bank
// assumes an apb master with 32-bit data; each register index sits at byte address 4 * index
package buffer_pointer_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BUFFER_RESET    = 8'h53;
    localparam logic [7:0] IDX_BUFFER_SIZE     = 8'h56;
    localparam logic [7:0] IDX_DISK_LOW        = 8'h57;
    localparam logic [7:0] IDX_DISK_MIDDLE     = 8'h58;
    localparam logic [7:0] IDX_DISK_HIGH       = 8'h59;
    localparam logic [7:0] IDX_HOST_LOW        = 8'h5a;
    localparam logic [7:0] IDX_HOST_MIDDLE     = 8'h5b;
    localparam logic [7:0] IDX_HOST_HIGH       = 8'h5c;
    localparam logic [7:0] IDX_STOP_LOW        = 8'h5d;
    localparam logic [7:0] IDX_STOP_MIDDLE     = 8'h5e;
    localparam logic [7:0] IDX_STOP_HIGH       = 8'h5f;

    // field layout
    localparam int unsigned POINTER_WIDTH      = 22;
    localparam int unsigned HIGH_BYTE_BITS     = 6;
    localparam int unsigned SOFT_RESET_BIT     = 5;
    localparam int unsigned SIZE_CODES         = 8;

    // values after reset
    localparam logic [7:0]  SIZE_RESET         = 8'h00;
    localparam logic        SOFT_RESET_AT_POR  = 1'b1;
    localparam logic        SCSI_RESET_IDLE    = 1'b1;

    // address bits kept by the buffer for size code with n low ones
    localparam int unsigned BUFFER_BITS [SIZE_CODES] = '{13, 14, 15, 16, 17, 18, 20, 22};

endpackage

// >>> verilog/buffer_pointer_regs.sv
// buffer size code, disk / host / stop pointers and host-side soft reset bit
// assumes an apb3 master on pclk and an asynchronous active-low scsi bus reset pin
// Behaviour
// RQ1: an 8-bit read/write size register holds a code of low ones, 00 to 7f, choosing buffer size.
// RQ2: the size code masks the host-to-stop compare so it respects the buffer wrap boundary.
// RQ3: the size register clears on hardware reset only, not on soft or scsi bus reset.
// RQ4: a 22-bit disk pointer in low, middle and 6-bit high bytes addresses disk and controller access.
// RQ5: all pointer bytes clear on hardware reset and while the host/buffer reset bit is set.
// RQ6: a 22-bit host pointer in low, middle and 6-bit high bytes addresses host-side access.
// RQ7: a 22-bit stop pointer in low, middle and 6-bit high bytes marks the host-side limit.
// RQ8: host and stop pointers also clear on scsi bus reset, the disk pointer does not.
// RQ9: the host/buffer reset bit, set by software or by hardware reset, halts buffer and host work.
// RQ10: reserved high-byte bits read zero and ignore writes; each pointer is one 22-bit value.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

module buffer_pointer_regs #(
    parameter int unsigned ADDR_WIDTH = 10
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_WIDTH-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    scsi_reset_n,
    output logic      [7:0]              buffer_size_code,
    output logic      [21:0]             disk_address,
    output logic      [21:0]             host_address,
    output logic      [21:0]             stop_address,
    output logic                         host_at_stop,
    output logic                         buffer_halt
);

    localparam int unsigned PW = buffer_pointer_pkg::POINTER_WIDTH;
    localparam int unsigned HB = buffer_pointer_pkg::HIGH_BYTE_BITS;

    typedef struct packed {
        logic [7:0]    size;
        logic [PW-1:0] disk;
        logic [PW-1:0] host;
        logic [PW-1:0] stop;
        logic          soft_reset;
        logic          at_stop;
        logic [31:0]   rdata;
    } regs_state_t;

    regs_state_t state;
    regs_state_t next_state;

    logic          scsi_level;
    logic [7:0]    index;
    logic          aligned;
    logic          hit;
    logic          setup;
    logic          access;
    logic          wr_en;

    pin_sync #(
        .RESET_LEVEL (buffer_pointer_pkg::SCSI_RESET_IDLE)
    ) u_scsi_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .pin_in    (scsi_reset_n),
        .level_out (scsi_level)
    );

    // size mask; an illegal code keeps every address bit so nothing wraps early
    function automatic logic [PW-1:0] size_mask(input logic [7:0] code);
        logic [PW-1:0] mask;
        mask = {PW{1'b1}};
        for (int i = 0; i < buffer_pointer_pkg::SIZE_CODES; i++) begin
            if (code == 8'((16'h0001 << i) - 16'h0001)) begin
                mask = PW'((32'h0000_0001 << buffer_pointer_pkg::BUFFER_BITS[i]) - 32'h0000_0001);
            end
        end
        return mask;
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        return (idx == buffer_pointer_pkg::IDX_BUFFER_RESET) ||
               ((idx >= buffer_pointer_pkg::IDX_BUFFER_SIZE) &&
                (idx <= buffer_pointer_pkg::IDX_STOP_HIGH));
    endfunction

    // high bytes carry only the six live bits
    function automatic logic [7:0] high_byte(input logic [PW-1:0] ptr);
        return {2'b00, ptr[PW-1:16]};
    endfunction

    function automatic logic [31:0] read_value(input regs_state_t s, input logic [7:0] idx);
        logic [7:0] value;
        value = 8'h00;
        unique case (idx)
            buffer_pointer_pkg::IDX_BUFFER_RESET: value[buffer_pointer_pkg::SOFT_RESET_BIT] =
                                                      s.soft_reset;
            buffer_pointer_pkg::IDX_BUFFER_SIZE:  value = s.size;
            buffer_pointer_pkg::IDX_DISK_LOW:     value = s.disk[7:0];
            buffer_pointer_pkg::IDX_DISK_MIDDLE:  value = s.disk[15:8];
            buffer_pointer_pkg::IDX_DISK_HIGH:    value = high_byte(s.disk);
            buffer_pointer_pkg::IDX_HOST_LOW:     value = s.host[7:0];
            buffer_pointer_pkg::IDX_HOST_MIDDLE:  value = s.host[15:8];
            buffer_pointer_pkg::IDX_HOST_HIGH:    value = high_byte(s.host);
            buffer_pointer_pkg::IDX_STOP_LOW:     value = s.stop[7:0];
            buffer_pointer_pkg::IDX_STOP_MIDDLE:  value = s.stop[15:8];
            buffer_pointer_pkg::IDX_STOP_HIGH:    value = high_byte(s.stop);
            default:                              value = 8'h00;
        endcase
        return {24'h00_0000, value};
    endfunction

    assign index   = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign hit     = aligned && mapped(index);
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign wr_en   = clk_en && access && pwrite && hit;

    // zero wait states; a stalled clock enable still answers, but no state moves
    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    always_comb begin
        next_state = state;
        if (clk_en) begin
            // read data sampled in the setup cycle, reads have no side effects
            if (setup && !pwrite) begin
                next_state.rdata = hit ? read_value(state, index) : 32'h0000_0000;
            end
            if (wr_en) begin
                unique case (index)
                    // RQ9: soft reset bit
                    buffer_pointer_pkg::IDX_BUFFER_RESET:
                        next_state.soft_reset = pwdata[buffer_pointer_pkg::SOFT_RESET_BIT];
                    // RQ1: size code write
                    buffer_pointer_pkg::IDX_BUFFER_SIZE:  next_state.size        = pwdata[7:0];
                    // RQ4: disk pointer bytes
                    buffer_pointer_pkg::IDX_DISK_LOW:     next_state.disk[7:0]   = pwdata[7:0];
                    buffer_pointer_pkg::IDX_DISK_MIDDLE:  next_state.disk[15:8]  = pwdata[7:0];
                    // RQ10: reserved bits dropped on write
                    buffer_pointer_pkg::IDX_DISK_HIGH:    next_state.disk[PW-1:16] = pwdata[HB-1:0];
                    // RQ6: host pointer bytes
                    buffer_pointer_pkg::IDX_HOST_LOW:     next_state.host[7:0]   = pwdata[7:0];
                    buffer_pointer_pkg::IDX_HOST_MIDDLE:  next_state.host[15:8]  = pwdata[7:0];
                    buffer_pointer_pkg::IDX_HOST_HIGH:    next_state.host[PW-1:16] = pwdata[HB-1:0];
                    // RQ7: stop pointer bytes
                    buffer_pointer_pkg::IDX_STOP_LOW:     next_state.stop[7:0]   = pwdata[7:0];
                    buffer_pointer_pkg::IDX_STOP_MIDDLE:  next_state.stop[15:8]  = pwdata[7:0];
                    buffer_pointer_pkg::IDX_STOP_HIGH:    next_state.stop[PW-1:16] = pwdata[HB-1:0];
                    default: ;
                endcase
            end
            // RQ5: soft reset holds every pointer at zero, over any write
            if (state.soft_reset) begin
                next_state.disk = '0;
                next_state.host = '0;
                next_state.stop = '0;
            end
            // RQ8: scsi bus reset clears host side only
            if (!scsi_level) begin
                next_state.host = '0;
                next_state.stop = '0;
            end
            // RQ2: compare within the physical buffer only
            next_state.at_stop = ((next_state.host ^ next_state.stop) &
                                  size_mask(next_state.size)) == '0;
        end
    end

    // RQ3: only the pin reset reaches the size code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= '0;
            state.size       <= buffer_pointer_pkg::SIZE_RESET;
            state.soft_reset <= buffer_pointer_pkg::SOFT_RESET_AT_POR;
            state.at_stop    <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign prdata           = state.rdata;
    assign buffer_size_code = state.size;
    assign disk_address     = state.disk;
    assign host_address     = state.host;
    assign stop_address     = state.stop;
    assign host_at_stop     = state.at_stop;
    // RQ9: halt follows the soft reset bit
    assign buffer_halt      = state.soft_reset;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_size_write: assert property ( // RQ1
        wr_en && index == buffer_pointer_pkg::IDX_BUFFER_SIZE
        |=> buffer_size_code == $past(pwdata[7:0]))
        else $error("size code not taken from write");

    chk_stop_compare: assert property ( // RQ2
        host_at_stop == (((host_address ^ stop_address) & size_mask(buffer_size_code)) == '0))
        else $error("host stop compare ignores size mask");

    chk_size_kept: assert property ( // RQ3
        clk_en && (buffer_halt || !scsi_level) &&
        !(wr_en && index == buffer_pointer_pkg::IDX_BUFFER_SIZE)
        |=> $stable(buffer_size_code))
        else $error("size code moved under soft or scsi reset");

    chk_disk_write: assert property ( // RQ4
        wr_en && index == buffer_pointer_pkg::IDX_DISK_MIDDLE && !buffer_halt
        |=> disk_address[15:8] == $past(pwdata[7:0]))
        else $error("disk middle byte not written");

    chk_soft_clear: assert property ( // RQ5
        clk_en && buffer_halt
        |=> disk_address == '0 && host_address == '0 && stop_address == '0)
        else $error("pointers not cleared by soft reset");

    chk_host_write: assert property ( // RQ6
        wr_en && index == buffer_pointer_pkg::IDX_HOST_LOW && !buffer_halt && scsi_level
        |=> host_address[7:0] == $past(pwdata[7:0]))
        else $error("host low byte not written");

    chk_stop_write: assert property ( // RQ7
        wr_en && index == buffer_pointer_pkg::IDX_STOP_HIGH && !buffer_halt && scsi_level
        |=> stop_address[21:16] == $past(pwdata[5:0]))
        else $error("stop high byte not written");

    chk_scsi_clear: assert property ( // RQ8
        clk_en && !scsi_level && !buffer_halt && !wr_en
        |=> host_address == '0 && stop_address == '0 && $stable(disk_address))
        else $error("scsi reset clear wrong");

    chk_halt_write: assert property ( // RQ9
        wr_en && index == buffer_pointer_pkg::IDX_BUFFER_RESET
        |=> buffer_halt == $past(pwdata[5]))
        else $error("soft reset bit not written");

    chk_reserved_zero: assert property ( // RQ10
        clk_en && setup && !pwrite && aligned &&
        (index == buffer_pointer_pkg::IDX_DISK_HIGH || index == buffer_pointer_pkg::IDX_HOST_HIGH ||
         index == buffer_pointer_pkg::IDX_STOP_HIGH)
        |=> prdata[31:6] == '0)
        else $error("reserved high bits not zero");

    // clock enable low must freeze every register, synchroniser included
    chk_freeze_state: assert property ( // RQ1
        !clk_en |=> $stable(buffer_size_code) && $stable(disk_address) &&
        $stable(host_address) && $stable(stop_address) && $stable(buffer_halt) &&
        $stable(host_at_stop) && $stable(prdata))
        else $error("state moved with clock enable low");

    // read-back checks: prdata is loaded from the setup cycle
    chk_size_read: assert property ( // RQ1
        clk_en && setup && !pwrite && aligned && index == buffer_pointer_pkg::IDX_BUFFER_SIZE
        |=> prdata == {24'h00_0000, $past(buffer_size_code)})
        else $error("size code read back wrong");

    // size compare seen from outside; code 00 keeps 13 bits, code 7f all 22
    chk_stop_match: assert property ( // RQ2
        buffer_size_code == 8'h00 && host_address[12:0] == stop_address[12:0] |-> host_at_stop)
        else $error("small buffer compare missed a wrapped match");

    chk_stop_differ: assert property ( // RQ2
        buffer_size_code == 8'h7f && host_address != stop_address |-> !host_at_stop)
        else $error("full buffer compare hid a difference");

    // write checks: a byte lands one edge after its access cycle
    chk_disk_low: assert property ( // RQ4
        wr_en && index == buffer_pointer_pkg::IDX_DISK_LOW && !buffer_halt
        |=> disk_address[7:0] == $past(pwdata[7:0]))
        else $error("disk low byte not written");

    chk_disk_high: assert property ( // RQ4
        wr_en && index == buffer_pointer_pkg::IDX_DISK_HIGH && !buffer_halt
        |=> disk_address[21:16] == $past(pwdata[5:0]))
        else $error("disk high byte not written");

    // hold checks: nothing moves without a write or a reset source
    chk_disk_kept: assert property ( // RQ4
        clk_en && !buffer_halt && !(wr_en && index >= buffer_pointer_pkg::IDX_DISK_LOW &&
        index <= buffer_pointer_pkg::IDX_DISK_HIGH) |=> $stable(disk_address))
        else $error("disk pointer moved without a write");

    chk_disk_read: assert property ( // RQ4
        clk_en && setup && !pwrite && aligned && index == buffer_pointer_pkg::IDX_DISK_LOW
        |=> prdata == {24'h00_0000, $past(disk_address[7:0])})
        else $error("disk low byte read back wrong");

    chk_host_middle: assert property ( // RQ6
        wr_en && index == buffer_pointer_pkg::IDX_HOST_MIDDLE && !buffer_halt && scsi_level
        |=> host_address[15:8] == $past(pwdata[7:0]))
        else $error("host middle byte not written");

    chk_host_high: assert property ( // RQ6
        wr_en && index == buffer_pointer_pkg::IDX_HOST_HIGH && !buffer_halt && scsi_level
        |=> host_address[21:16] == $past(pwdata[5:0]))
        else $error("host high byte not written");

    chk_host_read: assert property ( // RQ6
        clk_en && setup && !pwrite && aligned && index == buffer_pointer_pkg::IDX_HOST_MIDDLE
        |=> prdata == {24'h00_0000, $past(host_address[15:8])})
        else $error("host middle byte read back wrong");

    chk_stop_low: assert property ( // RQ7
        wr_en && index == buffer_pointer_pkg::IDX_STOP_LOW && !buffer_halt && scsi_level
        |=> stop_address[7:0] == $past(pwdata[7:0]))
        else $error("stop low byte not written");

    chk_stop_middle: assert property ( // RQ7
        wr_en && index == buffer_pointer_pkg::IDX_STOP_MIDDLE && !buffer_halt && scsi_level
        |=> stop_address[15:8] == $past(pwdata[7:0]))
        else $error("stop middle byte not written");

    chk_stop_read: assert property ( // RQ7
        clk_en && setup && !pwrite && aligned && index == buffer_pointer_pkg::IDX_STOP_HIGH
        |=> prdata == {26'h000_0000, $past(stop_address[21:16])})
        else $error("stop high byte read back wrong");

    chk_host_kept: assert property ( // RQ8
        clk_en && !buffer_halt && scsi_level && !(wr_en &&
        index >= buffer_pointer_pkg::IDX_HOST_LOW && index <= buffer_pointer_pkg::IDX_STOP_HIGH)
        |=> $stable(host_address) && $stable(stop_address))
        else $error("host side pointers moved without a write");

    chk_halt_kept: assert property ( // RQ9
        !(wr_en && index == buffer_pointer_pkg::IDX_BUFFER_RESET)
        |=> $stable(buffer_halt))
        else $error("reset bit moved without a write");

    chk_halt_read: assert property ( // RQ9
        clk_en && setup && !pwrite && aligned && index == buffer_pointer_pkg::IDX_BUFFER_RESET
        |=> prdata == {26'h000_0000, $past(buffer_halt), 5'h00})
        else $error("reset bit read back wrong");

    chk_unmapped_read: assert property ( // RQ10
        clk_en && setup && !pwrite && !hit |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule

// >>> verilog/pin_sync.sv
// three-stage synchroniser for one asynchronous pin
// assumes pclk domain; the output moves only when stages two and three agree
`timescale 1ns/1ps

module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      level_out
);

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
        logic level;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // stage1 feeds stage2 only, to keep metastability out of the compare
    always_comb begin
        next_state = state;
        if (clk_en) begin
            next_state.stage1 = pin_in;
            next_state.stage2 = state.stage1;
            next_state.stage3 = state.stage2;
            if (state.stage2 == state.stage3) begin
                next_state.level = state.stage3;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= {4{RESET_LEVEL}};
        end else begin
            state <= next_state;
        end
    end

    assign level_out = state.level;

endmodule
